/* File: rtl/e1_loopback_test_controller.sv */
// operator driven loopback test controller for the e1 line side card
`timescale 1ns/1ps
`default_nettype none
`include "loopback_test_map.svh"

// Overview of operation
// - test types 1 local, 2 external, 3 network; others rejected.
// - cancel at selection abandons request, no test starts.
// - duration 0 single pass (network test runs until stop), 1..98 minutes, 99 continuous.
// - confirmation step; quit aborts, any other key proceeds.
// - detected failures never abort a running test.
// - stop ends any timed or continuous test; 99 ends only by stop.
// - every invalid received word increments the failure count until it reaches 65000.
// - failure count saturates at 65000, never wraps.
// - failure count reported when test ends, zero included.
// - local test loops transmit to receive at backplane, all timeslots.
// - external test sends and checks all timeslots; far end loops.
// - network test returns received e1 data toward the far equipment.
// - network test neither generates nor checks words.
module e1_loopback_test_controller #(
    // a minute at 125 MHz does not fit a 32 bit int
    parameter longint CYCLES_PER_MINUTE =
        longint'(`CLK_FREQ_HZ) * longint'(`MINUTE_SECONDS)
) (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          select_valid,
    input  wire logic [1:0]                    select_test,
    input  wire logic                          select_cancel,
    input  wire logic                          duration_valid,
    input  wire logic [6:0]                    duration_minutes,
    input  wire logic                          confirm_valid,
    input  wire logic                          confirm_quit,
    input  wire logic                          stop_test,
    input  wire logic                          slot_strobe,
    input  wire logic [7:0]                    line_rx_word,
    input  wire logic [7:0]                    bp_tx_word,
    output var  logic                          select_reject,
    output var  logic                          request_aborted,
    output var  logic                          test_running,
    output var  loopback_test_pkg::path_mode_type path_mode,
    output var  logic [7:0]                    line_tx_word,
    output var  logic [7:0]                    bp_rx_word,
    output var  logic                          result_valid,
    output var  logic [15:0]                   result_failures
);
    import loopback_test_pkg::*;

    ctl_state_type state_reg, state_next;
    logic [1:0]  test_reg, test_next;
    logic [6:0]  dur_reg, dur_next;
    logic [32:0] tick_reg, tick_next;
    logic [6:0]  min_reg, min_next;
    logic [4:0]  slot_reg, slot_next;
    logic [15:0] fail_reg, fail_next;
    logic        reject_reg, reject_next;
    logic        abort_reg, abort_next;
    logic        res_v_reg, res_v_next;
    logic [15:0] res_reg, res_next;
    logic [7:0]  ltx_reg, ltx_next;
    logic [7:0]  brx_reg, brx_next;
    logic        checking;
    logic        word_bad;
    logic        run_done;
    logic [7:0]  rx_check_word;

    pattern_if pat ();

    test_pattern_gen u_pattern (
        .clk   (clk),
        .rst_n (rst_n),
        .pat   (pat.gen)
    );

    // network test carries no pattern traffic
    assign checking = (state_reg == ST_RUN) && (test_reg != `TEST_NETWORK);
    // local test loops the transmit register inside the card; the looped
    // word lags the pattern by one cycle, so strobes must not be adjacent
    assign rx_check_word = (test_reg == `TEST_LOCAL) ? ltx_reg
                                                     : line_rx_word;
    assign word_bad = checking && slot_strobe
                      && (rx_check_word != pat.word);
    assign pat.restart = (state_reg == ST_CONFIRM);
    assign pat.advance = checking && slot_strobe;

    // a single pass of the local or external test ends after the last of the 32 timeslots
    assign run_done = (dur_reg == `DUR_ONCE)
                    ? (slot_strobe && slot_reg == `LAST_TIMESLOT
                       && test_reg != `TEST_NETWORK)
                    : (dur_reg != `DUR_FOREVER
                       && min_reg == dur_reg);

    always_comb begin
        state_next  = state_reg;
        test_next   = test_reg;
        dur_next    = dur_reg;
        tick_next   = tick_reg;
        min_next    = min_reg;
        slot_next   = slot_reg;
        fail_next   = fail_reg;
        reject_next = 1'b0;
        abort_next  = 1'b0;
        res_v_next  = 1'b0;
        res_next    = res_reg;
        case (state_reg)
            ST_IDLE: begin
                if (select_valid || select_cancel) begin
                    state_next = ST_SELECT;
                end
            end
            ST_SELECT: begin
                if (select_cancel) begin
                    abort_next = 1'b1;
                    state_next = ST_IDLE;
                end else if (select_valid) begin
                    if (select_test == 2'h0) begin
                        reject_next = 1'b1;
                    end else begin
                        test_next  = select_test;
                        state_next = ST_DURATION;
                    end
                end
            end
            ST_DURATION: begin
                if (duration_valid) begin
                    if (duration_minutes > `DUR_FOREVER) begin
                        reject_next = 1'b1;
                    end else begin
                        dur_next   = duration_minutes;
                        state_next = ST_CONFIRM;
                    end
                end
            end
            ST_CONFIRM: begin
                if (confirm_valid) begin
                    if (confirm_quit) begin
                        abort_next = 1'b1;
                        state_next = ST_IDLE;
                    end else begin
                        state_next = ST_RUN;
                        tick_next  = '0;
                        min_next   = '0;
                        slot_next  = '0;
                        fail_next  = '0;
                    end
                end
            end
            ST_RUN: begin
                if (tick_reg == 33'(CYCLES_PER_MINUTE - 1)) begin
                    tick_next = '0;
                    if (min_reg != `DUR_FOREVER) begin
                        min_next = min_reg + 7'h01;
                    end
                end else begin
                    tick_next = tick_reg + 33'h0_0000_0001;
                end
                if (slot_strobe) begin
                    slot_next = slot_reg + 5'h01;
                end
                // failures only count; they never end the run
                if (word_bad && fail_reg != `FAIL_LIMIT) begin
                    fail_next = fail_reg + 16'h0001;
                end
                if (stop_test || run_done) begin
                    state_next = ST_REPORT;
                end
            end
            ST_REPORT: begin
                res_next   = fail_reg;
                res_v_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // data path switching per test type
    always_comb begin
        ltx_next = bp_tx_word;
        brx_next = line_rx_word;
        if (state_reg == ST_RUN) begin
            case (test_reg)
                `TEST_LOCAL: begin
                    ltx_next = pat.word;
                    brx_next = pat.word;
                end
                `TEST_EXTERNAL: begin
                    ltx_next = pat.word;
                end
                `TEST_NETWORK: begin
                    ltx_next = line_rx_word;
                end
                default: begin
                    ltx_next = bp_tx_word;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= ST_IDLE;
            test_reg   <= 2'h0;
            dur_reg    <= 7'h00;
            tick_reg   <= 33'h0_0000_0000;
            min_reg    <= 7'h00;
            slot_reg   <= 5'h00;
            fail_reg   <= 16'h0000;
            reject_reg <= 1'b0;
            abort_reg  <= 1'b0;
            res_v_reg  <= 1'b0;
            res_reg    <= 16'h0000;
            ltx_reg    <= 8'h00;
            brx_reg    <= 8'h00;
        end else begin
            state_reg  <= state_next;
            test_reg   <= test_next;
            dur_reg    <= dur_next;
            tick_reg   <= tick_next;
            min_reg    <= min_next;
            slot_reg   <= slot_next;
            fail_reg   <= fail_next;
            reject_reg <= reject_next;
            abort_reg  <= abort_next;
            res_v_reg  <= res_v_next;
            res_reg    <= res_next;
            ltx_reg    <= ltx_next;
            brx_reg    <= brx_next;
        end
    end

    assign select_reject   = reject_reg;
    assign request_aborted = abort_reg;
    assign test_running    = (state_reg == ST_RUN);
    assign path_mode       = (state_reg != ST_RUN) ? PATH_NORMAL
                           : path_mode_type'(test_reg);
    assign line_tx_word    = ltx_reg;
    assign bp_rx_word      = brx_reg;
    assign result_valid    = res_v_reg;
    assign result_failures = res_reg;

    chk_fail_saturate: assert property (@(posedge clk) disable iff (!rst_n)
        fail_reg == `FAIL_LIMIT |=> fail_reg == `FAIL_LIMIT
        || $past(state_reg) != ST_RUN)
        else $error("failure count wrapped");
    chk_fail_step: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_RUN && word_bad && fail_reg != `FAIL_LIMIT)
        |=> fail_reg == $past(fail_reg) + 16'h0001)
        else $error("bad word not counted");
    chk_net_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_RUN && test_reg == `TEST_NETWORK)
        |=> fail_reg == $past(fail_reg))
        else $error("network test counted");
    chk_stop_ends: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_RUN && stop_test)
        |=> state_reg == ST_REPORT ##1 result_valid)
        else $error("stop did not end test");
    chk_report_value: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == ST_REPORT |=> result_failures == $past(fail_reg))
        else $error("wrong failure report");
    chk_cancel_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_SELECT && select_cancel)
        |=> state_reg == ST_IDLE && request_aborted)
        else $error("cancel did not abandon");
    chk_quit_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_CONFIRM && confirm_valid && confirm_quit)
        |=> !test_running ##1 !test_running)
        else $error("quit started a test");
    chk_bad_select: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_SELECT && select_valid && !select_cancel
         && select_test == 2'h0) |=> select_reject && state_reg == ST_SELECT)
        else $error("bad test accepted");
    chk_no_abort: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_RUN && word_bad && !stop_test && !run_done)
        |=> state_reg == ST_RUN)
        else $error("failure aborted test");
    chk_local_loop: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_RUN && test_reg == `TEST_LOCAL)
        |=> bp_rx_word == line_tx_word)
        else $error("local loop broken");
endmodule
`default_nettype wire

/* File: rtl/loopback_test_map.svh */
// constants for the e1 loopback test controller
`ifndef LOOPBACK_TEST_MAP_SVH
`define LOOPBACK_TEST_MAP_SVH
`define TEST_LOCAL        2'h1
`define TEST_EXTERNAL     2'h2
`define TEST_NETWORK      2'h3
`define DUR_ONCE          7'h00
`define DUR_MAX_MINUTES   7'h62
`define DUR_FOREVER       7'h63
`define FAIL_LIMIT        16'hFDE8
`define NUM_TIMESLOTS     6'h20
`define LAST_TIMESLOT     5'h1F
`define CLK_FREQ_HZ       125000000
`define MINUTE_SECONDS    60
`define PRBS_SEED         15'h7FFF
`endif

/* File: rtl/loopback_test_pkg.sv */
// types for the e1 loopback test controller
package loopback_test_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SELECT,
        ST_DURATION,
        ST_CONFIRM,
        ST_RUN,
        ST_REPORT
    } ctl_state_type;
    typedef enum logic [1:0] {
        PATH_NORMAL,
        PATH_LOCAL,
        PATH_EXTERNAL,
        PATH_NETWORK
    } path_mode_type;
endpackage

/* File: rtl/pattern_if.sv */
// shared pattern request/answer between controller and pattern generator
`timescale 1ns/1ps
`default_nettype none
interface pattern_if;
    logic       restart;
    logic       advance;
    logic [7:0] word;
    modport ctl (output restart, output advance, input word);
    modport gen (input restart, input advance, output word);
endinterface
`default_nettype wire

/* File: rtl/test_pattern_gen.sv */
// deterministic test word source shared by generator and checker
`timescale 1ns/1ps
`default_nettype none
`include "loopback_test_map.svh"
module test_pattern_gen (
    input wire logic clk,
    input wire logic rst_n,
    pattern_if.gen   pat
);
    import loopback_test_pkg::*;
    logic [14:0] lfsr_reg;
    logic [14:0] lfsr_next;

    // prbs15 stepped eight bits per timeslot
    always_comb begin
        lfsr_next = lfsr_reg;
        if (pat.restart) begin
            lfsr_next = `PRBS_SEED;
        end else if (pat.advance) begin
            for (int i = 0; i < 8; i++) begin
                lfsr_next = {lfsr_next[13:0], lfsr_next[14] ^ lfsr_next[13]};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_reg <= `PRBS_SEED;
        end else begin
            lfsr_reg <= lfsr_next;
        end
    end

    assign pat.word = lfsr_reg[7:0];
endmodule
`default_nettype wire

/* File: verif/e1_far_end_model.sv */
// far end of the e1 link: loop plug during external test, else cpe traffic
`timescale 1ns/1ps
`default_nettype none
module e1_far_end_model (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       slot_strobe,
    input  wire logic       loop_on,
    input  wire logic       corrupt,
    input  wire logic [7:0] line_tx_word,
    output var  logic [7:0] line_rx_word
);
    logic [7:0] cpe_word_reg;
    logic [7:0] cpe_word_next;

    // cpe sends a fresh word every timeslot so a stale loop shows up
    always_comb begin
        cpe_word_next = slot_strobe ? cpe_word_reg + 8'h3B : cpe_word_reg;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpe_word_reg <= 8'h5A;
        end else begin
            cpe_word_reg <= cpe_word_next;
        end
    end

    // corruption inverts every bit so any checker width sees it
    always_comb begin
        if (loop_on) begin
            line_rx_word = line_tx_word ^ (corrupt ? 8'hFF : 8'h00);
        end else begin
            line_rx_word = cpe_word_reg;
        end
    end
endmodule
`default_nettype wire

/* File: verif/e1_loopback_test_controller_tb.sv */
// self-checking bench for the e1 loopback test controller
`timescale 1ns/1ps
`default_nettype none
`include "loopback_test_map.svh"
`define CHECK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    errors++; $display("wrong value %s expected %0h seen %0h", nm, exp, got); \
    end end
module e1_loopback_test_controller_tb;
    import loopback_test_pkg::*;
    localparam int CPM = 100;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    logic          select_valid = 1'b0;
    logic [1:0]    select_test = 2'h0;
    logic          select_cancel = 1'b0;
    logic          duration_valid = 1'b0;
    logic [6:0]    duration_minutes = 7'h00;
    logic          confirm_valid = 1'b0;
    logic          confirm_quit = 1'b0;
    logic          stop_test = 1'b0;
    logic          slot_strobe = 1'b0;
    logic          corrupt = 1'b0;
    logic [7:0]    line_rx_word;
    logic [7:0]    bp_tx_word = 8'h00;
    logic          select_reject;
    logic          request_aborted;
    logic          test_running;
    path_mode_type path_mode;
    logic [7:0]    line_tx_word;
    logic [7:0]    bp_rx_word;
    logic          result_valid;
    logic [15:0]   result_failures;
    logic [7:0]    exp_word;
    int            errors = 0;
    int            compares = 0;
    int            cycles = 0;

    e1_loopback_test_controller #(.CYCLES_PER_MINUTE(CPM)) DUT (
        .clk(clk), .rst_n(rst_n), .select_valid(select_valid),
        .select_test(select_test), .select_cancel(select_cancel),
        .duration_valid(duration_valid), .duration_minutes(duration_minutes),
        .confirm_valid(confirm_valid), .confirm_quit(confirm_quit),
        .stop_test(stop_test), .slot_strobe(slot_strobe),
        .line_rx_word(line_rx_word), .bp_tx_word(bp_tx_word),
        .select_reject(select_reject), .request_aborted(request_aborted),
        .test_running(test_running), .path_mode(path_mode),
        .line_tx_word(line_tx_word), .bp_rx_word(bp_rx_word),
        .result_valid(result_valid), .result_failures(result_failures));

    e1_far_end_model far_end (
        .clk(clk), .rst_n(rst_n), .slot_strobe(slot_strobe),
        .loop_on(path_mode == PATH_EXTERNAL), .corrupt(corrupt),
        .line_tx_word(line_tx_word), .line_rx_word(line_rx_word));

    always #4 clk = ~clk;

    task automatic print_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // longest run is the saturation test, about 66k cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 75000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic step;
        @(posedge clk);
        #1;
    endtask

    task automatic do_reset;
        rst_n = 1'b0;
        repeat (5) step();
        rst_n = 1'b1;
    endtask

    // idle needs one edge to reach selection, so the request is held two
    task automatic choose(input logic [1:0] t, input logic cancel);
        select_valid = !cancel;
        select_cancel = cancel;
        select_test = t;
        step();
        step();
        select_valid = 1'b0;
        select_cancel = 1'b0;
    endtask

    task automatic request(input logic [1:0] t, input logic [6:0] d,
                           input logic quit);
        choose(t, 1'b0);
        duration_valid = 1'b1;
        duration_minutes = d;
        step();
        duration_valid = 1'b0;
        confirm_valid = 1'b1;
        confirm_quit = quit;
        step();
        confirm_valid = 1'b0;
        confirm_quit = 1'b0;
    endtask

    // strobes sit two cycles apart: the looped word comes back from the
    // transmit register, one cycle after the pattern that it carries
    task automatic strobes(input int n, input int bad);
        for (int i = 0; i < n; i++) begin
            step();
            slot_strobe = 1'b1;
            corrupt = (i < bad);
            bp_tx_word = bp_tx_word + 8'h11;
            step();
            slot_strobe = 1'b0;
            corrupt = 1'b0;
        end
    endtask

    task automatic expect_pulse(input int which, input int limit);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < limit && !seen; i++) begin
            case (which)
                0: seen = (select_reject === 1'b1);
                1: seen = (request_aborted === 1'b1);
                default: seen = (result_valid === 1'b1);
            endcase
            if (!seen) step();
        end
        `CHECK("pulse", 1'b1, seen)
    endtask

    task automatic stop_and_result(input logic [15:0] fails);
        stop_test = 1'b1;
        step();
        stop_test = 1'b0;
        expect_pulse(2, 4);
        `CHECK("failures", fails, result_failures)
    endtask

    initial begin
        do_reset();
        `CHECK("idle run", 1'b0, test_running)
        `CHECK("idle path", PATH_NORMAL, path_mode)
        `CHECK("idle result", 16'h0000, result_failures)
        choose(2'h0, 1'b0);
        expect_pulse(0, 3);
        do_reset();
        choose(`TEST_LOCAL, 1'b1);
        expect_pulse(1, 3);
        `CHECK("cancel run", 1'b0, test_running)
        do_reset();
        choose(`TEST_LOCAL, 1'b0);
        duration_valid = 1'b1;
        duration_minutes = 7'h64;
        step();
        duration_valid = 1'b0;
        expect_pulse(0, 3);
        do_reset();
        request(`TEST_EXTERNAL, `DUR_ONCE, 1'b1);
        expect_pulse(1, 3);
        `CHECK("quit run", 1'b0, test_running)
        do_reset();
        request(`TEST_LOCAL, `DUR_ONCE, 1'b0);
        `CHECK("local path", PATH_LOCAL, path_mode)
        strobes(31, 0);
        `CHECK("pass open", 1'b1, test_running)
        strobes(1, 0);
        expect_pulse(2, 4);
        `CHECK("local fails", 16'h0000, result_failures)
        request(`TEST_EXTERNAL, `DUR_ONCE, 1'b0);
        `CHECK("ext path", PATH_EXTERNAL, path_mode)
        strobes(5, 5);
        `CHECK("ext alive", 1'b1, test_running)
        strobes(27, 0);
        expect_pulse(2, 4);
        `CHECK("ext fails", 16'h0005, result_failures)
        request(`TEST_LOCAL, 7'h02, 1'b0);
        repeat (150) step();
        `CHECK("timed alive", 1'b1, test_running)
        expect_pulse(2, 120);
        `CHECK("timed fails", 16'h0000, result_failures)
        request(`TEST_NETWORK, `DUR_FOREVER, 1'b0);
        `CHECK("net path", PATH_NETWORK, path_mode)
        repeat (4) begin
            exp_word = line_rx_word;
            strobes(1, 0);
            `CHECK("net echo", exp_word, line_tx_word)
            `CHECK("net rx", exp_word, bp_rx_word)
        end
        repeat (300) step();
        `CHECK("forever alive", 1'b1, test_running)
        stop_and_result(16'h0000);
        request(`TEST_EXTERNAL, `DUR_FOREVER, 1'b0);
        // back to back corrupted strobes: nearly every word misses, and
        // 66000 of them leave a wide margin over the ceiling
        slot_strobe = 1'b1;
        corrupt = 1'b1;
        repeat (66000) step();
        slot_strobe = 1'b0;
        corrupt = 1'b0;
        stop_and_result(`FAIL_LIMIT);
        print_verdict();
    end
endmodule
`default_nettype wire
